// ===== include/plsc_defs.svh
// Constants for the PIPE lane status and control block
`ifndef PLSC_DEFS_SVH
`define PLSC_DEFS_SVH

`define PLSC_MAX_LANES      8
`define PLSC_ADDR_W         12
`define PLSC_DATA_W         32

`define PLSC_OFF_TRAIN      12'h000
`define PLSC_OFF_RATE       12'h004
`define PLSC_OFF_IRQ_STS    12'h008
`define PLSC_OFF_IRQ_CLR    12'h00c
`define PLSC_OFF_IRQ_EN     12'h010
`define PLSC_OFF_LANE_RX    12'h014
`define PLSC_OFF_LANE_BASE  12'h020
`define PLSC_LANE_IDX_LSB   2
`define PLSC_LANE_IDX_MSB   4

`define PLSC_TS_W           5
`define PLSC_RATE_W         2
`define PLSC_RATE_RSV_BIT   1
`define PLSC_RATE_RST       2'h0
`define PLSC_STATUS_W       3
`define PLSC_MARGIN_W       3
`define PLSC_POWER_W        2
`define PLSC_LC_W           6
`define PLSC_LC_MARGIN_LSB  1
`define PLSC_LC_MARGIN_MSB  3
`define PLSC_LC_RST         6'h00
`define PLSC_MARGIN_RSV0    3'h2
`define PLSC_MARGIN_RSV1    3'h3
`define PLSC_RX_FIELD_W     4

`define PLSC_IRQ_W          17
`define PLSC_IRQ_IDLE_LSB   0
`define PLSC_IRQ_STAT_LSB   8
`define PLSC_IRQ_REFUSE     16

`define PLSC_TS_DETECT_QUIET    5'h00
`define PLSC_TS_DETECT_ACTIVE   5'h01
`define PLSC_TS_POLL_COMPLY     5'h03
`define PLSC_TS_POLL_CONFIG     5'h04
`define PLSC_TS_POLL_SPEED      5'h05
`define PLSC_TS_CFG_WAIT        5'h09
`define PLSC_TS_RCV_LOCK        5'h0c
`define PLSC_TS_RCV_IDLE        5'h0d
`define PLSC_TS_L0              5'h0f
`define PLSC_TS_DISABLE         5'h10
`define PLSC_TS_LPBK_ENTRY      5'h11
`define PLSC_TS_LPBK_EXIT       5'h13
`define PLSC_TS_L2_WAKE         5'h15
`define PLSC_TS_SPEED_RCV       5'h1a

`endif

// ===== include/plsc_pkg.sv
// Types for the PIPE lane status and control block
`default_nettype none
`include "plsc_defs.svh"
package plsc_pkg;
    typedef struct packed {
        logic [`PLSC_POWER_W-1:0]  power;
        logic [`PLSC_MARGIN_W-1:0] margin;
        logic                      swing;
    } plsc_lane_ctrl_t;
endpackage
`default_nettype wire

// ===== include/plsc_lane_if.sv
// Carrier between the register hub and one lane
`timescale 1ns/1ps
`default_nettype none
`include "plsc_defs.svh"
interface plsc_lane_if;
    plsc_pkg::plsc_lane_ctrl_t   ctrl;
    logic                        idle_q;
    logic [`PLSC_STATUS_W-1:0]   status_q;
    logic                        idle_evt;
    logic                        status_evt;
    modport hub  (output ctrl, input idle_q, input status_q, input idle_evt, input status_evt);
    modport lane (input ctrl, output idle_q, output status_q, output idle_evt, output status_evt);
endinterface
`default_nettype wire

// ===== hdl/plsc_lane.sv
// One PIPE lane: receive sampling and transmit control pins
`timescale 1ns/1ps
`default_nettype none
`include "plsc_defs.svh"
module plsc_lane (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        pipe_rise,
    input  wire logic                        rx_idle_pin,
    input  wire logic [`PLSC_STATUS_W-1:0]   rx_status_pin,
    plsc_lane_if.lane                        bus,
    output logic                             tx_swing,
    output logic [`PLSC_MARGIN_W-1:0]        tx_margin,
    output logic [`PLSC_POWER_W-1:0]         power_req
);
    logic                      idle_s1;
    logic                      idle_s2;
    logic [`PLSC_STATUS_W-1:0] stat_s1;
    logic [`PLSC_STATUS_W-1:0] stat_s2;
    logic                      idle_q;
    logic [`PLSC_STATUS_W-1:0] status_q;

    // ****************************************
    // Input synchronisers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_s1 <= 1'b0;
            idle_s2 <= 1'b0;
            stat_s1 <= '0;
            stat_s2 <= '0;
        end
        else
        begin
            idle_s1 <= rx_idle_pin;     // [R1]
            idle_s2 <= idle_s1;
            stat_s1 <= rx_status_pin;   // [R2]
            stat_s2 <= stat_s1;
        end
    end

    // ****************************************
    // Sample and drive on link clock rise
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_q    <= 1'b0;
            status_q  <= '0;
            tx_swing  <= 1'b0;
            tx_margin <= '0;
            power_req <= '0;
        end
        else if (pipe_rise)             // [R13]
        begin
            idle_q    <= idle_s2;
            status_q  <= stat_s2;
            tx_swing  <= bus.ctrl.swing;    // [R7]
            tx_margin <= bus.ctrl.margin;   // [R8] [R9]
            power_req <= bus.ctrl.power;    // [R12]
        end
    end

    // Events only ever reach status bits and irq, never the lane pins [R11]
    assign bus.idle_q     = idle_q;
    assign bus.status_q   = status_q;
    assign bus.idle_evt   = pipe_rise & (idle_s2 != idle_q);
    assign bus.status_evt = pipe_rise & (stat_s2 != status_q) & (|stat_s2);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_swing_follows_ctrl: assert property (pipe_rise |=> tx_swing == $past(bus.ctrl.swing)) // [R7]
        else $error("swing pin missed its control value");
    a_margin_no_reserved: assert property (tx_margin != `PLSC_MARGIN_RSV0 && tx_margin != `PLSC_MARGIN_RSV1) // [R8]
        else $error("reserved margin code on pin");
    a_margin_follows_ctrl: assert property (pipe_rise |=> tx_margin == $past(bus.ctrl.margin)) // [R9]
        else $error("margin pin missed its control value");
    a_power_holds_between: assert property (!pipe_rise |=> $stable(power_req)) // [R12]
        else $error("power request moved off a link clock rise");
endmodule // plsc_lane
`default_nettype wire

// ===== hdl/plsc_top.sv
// PIPE lane status and control block with APB registers
//
// Notes on behaviour
// R1: The PHY drives one receive electrical-idle level per lane into the block.
// R2: The PHY drives one 3-bit receive status code per lane into the block.
// R3: The training state output uses 00000, 00001, 00011 and 00100 for detect and polling; the code also uses 00101 (polling speed) and 01001 (config wait).
// R4: Recovery, L0, disable, loopback, L2 wake and speed recovery use their fixed 5-bit codes.
// R5: Lane rate 00 is 2.5 Gbps, 01 is 5.0 Gbps, and codes with the upper bit set are reserved.
// R6: The environment supplies the link interface clock derived from the reference clock.
// R7: Transmit swing 0 asks for full swing and 1 for half swing, per lane.
// R8: Transmit margin 000 is normal, 001 is the wide level, and 010 and 011 are reserved.
// R9: Transmit margin 100 to 111 all ask for the reduced level.
// R10: Every per-lane signal exists once for each lane, each lane independent.
// R11: The receive-side inputs may float without changing what the block drives; the code still lets them set interrupt status bits and so irq.
// R12: A 2-bit per-lane power request selects P0, P0s, P1 or P2.
// R13: All per-lane controls and status move on the rising edge of the link clock.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "plsc_defs.svh"
module plsc_top #(
    parameter int LANES = `PLSC_MAX_LANES
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic [`PLSC_ADDR_W-1:0]       paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [`PLSC_DATA_W-1:0]       pwdata,
    output logic [`PLSC_DATA_W-1:0]            prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          pipe_pclk,
    input  wire logic [LANES-1:0]              rx_idle_detect,
    input  wire logic [`PLSC_STATUS_W*LANES-1:0] rx_status_code,
    output logic [`PLSC_TS_W-1:0]              training_state,
    output logic [`PLSC_RATE_W-1:0]            lane_rate_select,
    output logic [LANES-1:0]                   tx_swing_select,
    output logic [`PLSC_MARGIN_W*LANES-1:0]    tx_level_margin,
    output logic [`PLSC_POWER_W*LANES-1:0]     power_state_request,
    output logic                               irq
);
    // ****************************************
    // Elaboration check
    // ****************************************
    generate
        if (LANES < 1 || LANES > `PLSC_MAX_LANES)
        begin : g_bad_lanes
            $error("LANES must lie between 1 and the lane maximum");
        end
    endgenerate

    // ****************************************
    // Declarations
    // ****************************************
    logic                              pipe_s1;
    logic                              pipe_s2;
    logic                              pipe_s3;
    wire                               pipe_rise;
    logic [`PLSC_TS_W-1:0]             train_shadow;
    logic [`PLSC_RATE_W-1:0]           rate_shadow;
    plsc_pkg::plsc_lane_ctrl_t         lane_ctrl [LANES];
    logic [`PLSC_IRQ_W-1:0]            irq_status;
    logic [`PLSC_IRQ_W-1:0]            irq_enable;
    logic [`PLSC_IRQ_W-1:0]            next_irq_status;
    logic [`PLSC_MAX_LANES-1:0]        idle_evt_v;
    logic [`PLSC_MAX_LANES-1:0]        stat_evt_v;
    logic [`PLSC_DATA_W-1:0]           lane_rx_word;
    plsc_lane_if                       lane_bus [LANES] ();

    // ****************************************
    // Link clock edge finder
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pipe_s1 <= 1'b0;
            pipe_s2 <= 1'b0;
            pipe_s3 <= 1'b0;
        end
        else
        begin
            pipe_s1 <= pipe_pclk;   // [R6]
            pipe_s2 <= pipe_s1;
            pipe_s3 <= pipe_s2;
        end
    end

    assign pipe_rise = pipe_s2 & ~pipe_s3;    // [R13]

    // ****************************************
    // APB decode
    // ****************************************
    function automatic logic ts_legal(input logic [`PLSC_TS_W-1:0] code);
        case (code)
            `PLSC_TS_DETECT_QUIET, `PLSC_TS_DETECT_ACTIVE,
            `PLSC_TS_POLL_COMPLY, `PLSC_TS_POLL_CONFIG,
            `PLSC_TS_POLL_SPEED, `PLSC_TS_CFG_WAIT:        ts_legal = 1'b1; // [R3]
            `PLSC_TS_RCV_LOCK, `PLSC_TS_RCV_IDLE, `PLSC_TS_L0,
            `PLSC_TS_DISABLE, `PLSC_TS_LPBK_ENTRY, `PLSC_TS_LPBK_EXIT,
            `PLSC_TS_L2_WAKE, `PLSC_TS_SPEED_RCV:          ts_legal = 1'b1; // [R4]
            default:                                       ts_legal = 1'b0;
        endcase
    endfunction

    wire                      acc_phase  = psel & penable;
    wire                      setup_rd   = psel & ~penable & ~pwrite;
    wire                      acc_wr     = acc_phase & pwrite;
    wire                      hit_train  = paddr == `PLSC_OFF_TRAIN;
    wire                      hit_rate   = paddr == `PLSC_OFF_RATE;
    wire                      hit_sts    = paddr == `PLSC_OFF_IRQ_STS;
    wire                      hit_clr    = paddr == `PLSC_OFF_IRQ_CLR;
    wire                      hit_en     = paddr == `PLSC_OFF_IRQ_EN;
    wire                      hit_rx     = paddr == `PLSC_OFF_LANE_RX;
    wire [`PLSC_ADDR_W-1:0]   lane_off   = paddr - `PLSC_OFF_LANE_BASE;
    wire [`PLSC_ADDR_W-1:0]   lane_top   = `PLSC_ADDR_W'(LANES << `PLSC_LANE_IDX_LSB);
    wire                      hit_lane   = (paddr >= `PLSC_OFF_LANE_BASE) && (lane_off < lane_top)
                                           && (paddr[`PLSC_LANE_IDX_LSB-1:0] == '0);
    wire [`PLSC_LANE_IDX_MSB-`PLSC_LANE_IDX_LSB:0] lane_idx =
                                           lane_off[`PLSC_LANE_IDX_MSB:`PLSC_LANE_IDX_LSB];
    wire                      mapped     = hit_train | hit_rate | hit_sts | hit_clr
                                           | hit_en | hit_rx | hit_lane;
    wire [`PLSC_MARGIN_W-1:0] wr_margin  = pwdata[`PLSC_LC_MARGIN_MSB:`PLSC_LC_MARGIN_LSB];
    wire                      bad_train  = hit_train & ~ts_legal(pwdata[`PLSC_TS_W-1:0]);
    wire                      bad_rate   = hit_rate & pwdata[`PLSC_RATE_RSV_BIT];       // [R5]
    wire                      bad_margin = hit_lane & (wr_margin == `PLSC_MARGIN_RSV0
                                           || wr_margin == `PLSC_MARGIN_RSV1);          // [R8]
    wire                      ro_write   = hit_sts | hit_rx;
    wire                      refuse     = bad_train | bad_rate | bad_margin | ro_write;
    wire                      wr_ok      = acc_wr & mapped & ~refuse;
    wire                      refuse_evt = acc_wr & mapped & refuse;

    assign pready  = 1'b1;
    assign pslverr = acc_phase & (~mapped | (pwrite & refuse));

    // ****************************************
    // Read data
    // ****************************************
    wire [`PLSC_DATA_W-1:0] rd_lane  = hit_lane
                                       ? `PLSC_DATA_W'(lane_ctrl[lane_idx]) : '0;
    wire [`PLSC_DATA_W-1:0] rd_value =
          hit_train ? `PLSC_DATA_W'(train_shadow)
        : hit_rate  ? `PLSC_DATA_W'(rate_shadow)
        : hit_sts   ? `PLSC_DATA_W'(irq_status)
        : hit_en    ? `PLSC_DATA_W'(irq_enable)
        : hit_rx    ? lane_rx_word
        : rd_lane;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (setup_rd)
            prdata <= rd_value;
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            train_shadow <= `PLSC_TS_DETECT_QUIET;
            rate_shadow  <= `PLSC_RATE_RST;
            irq_enable   <= '0;
        end
        else if (wr_ok)
        begin
            if (hit_train)
                train_shadow <= pwdata[`PLSC_TS_W-1:0];      // [R3] [R4]
            if (hit_rate)
                rate_shadow <= pwdata[`PLSC_RATE_W-1:0];     // [R5]
            if (hit_en)
                irq_enable <= pwdata[`PLSC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            training_state   <= `PLSC_TS_DETECT_QUIET;
            lane_rate_select <= `PLSC_RATE_RST;
        end
        else if (pipe_rise)                                  // [R13]
        begin
            training_state   <= train_shadow;               // [R3] [R4]
            lane_rate_select <= rate_shadow;                // [R5]
        end
    end

    // ****************************************
    // Lanes
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < `PLSC_MAX_LANES; i++)
        begin : g_lane
            if (i < LANES)
            begin : g_on
                always_ff @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                        lane_ctrl[i] <= `PLSC_LC_RST;
                    else if (wr_ok && hit_lane && lane_idx == i)
                        lane_ctrl[i] <= plsc_pkg::plsc_lane_ctrl_t'(pwdata[`PLSC_LC_W-1:0]);
                end

                assign lane_bus[i].ctrl = lane_ctrl[i];
                assign idle_evt_v[i]    = lane_bus[i].idle_evt;
                assign stat_evt_v[i]    = lane_bus[i].status_evt;
                assign lane_rx_word[i*`PLSC_RX_FIELD_W +: `PLSC_RX_FIELD_W] =
                    {lane_bus[i].status_q, lane_bus[i].idle_q};

                plsc_lane u_lane (                           // [R10]
                    .pclk          (pclk),
                    .presetn       (presetn),
                    .pipe_rise     (pipe_rise),
                    .rx_idle_pin   (rx_idle_detect[i]),
                    .rx_status_pin (rx_status_code[i*`PLSC_STATUS_W +: `PLSC_STATUS_W]),
                    .bus           (lane_bus[i]),
                    .tx_swing      (tx_swing_select[i]),
                    .tx_margin     (tx_level_margin[i*`PLSC_MARGIN_W +: `PLSC_MARGIN_W]),
                    .power_req     (power_state_request[i*`PLSC_POWER_W +: `PLSC_POWER_W])
                );
            end
            else
            begin : g_off
                assign idle_evt_v[i] = 1'b0;
                assign stat_evt_v[i] = 1'b0;
                assign lane_rx_word[i*`PLSC_RX_FIELD_W +: `PLSC_RX_FIELD_W] = '0;
            end
        end
    endgenerate

    // ****************************************
    // Interrupts
    // ****************************************
    wire [`PLSC_IRQ_W-1:0] irq_set = {refuse_evt, stat_evt_v, idle_evt_v};
    wire [`PLSC_IRQ_W-1:0] irq_clr = (acc_wr && hit_clr) ? pwdata[`PLSC_IRQ_W-1:0] : '0;

    // Set wins over a clear in the same cycle
    assign next_irq_status = (irq_status & ~irq_clr) | irq_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= '0;
        else
            irq_status <= next_irq_status;
    end

    assign irq = |(irq_status & irq_enable);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rate_bad_write;
        acc_wr && hit_rate && pwdata[`PLSC_RATE_RSV_BIT];
    endsequence

    sequence s_train_good_write;
        acc_wr && hit_train && ts_legal(pwdata[`PLSC_TS_W-1:0]);
    endsequence

    a_rate_never_reserved: assert property (!lane_rate_select[`PLSC_RATE_RSV_BIT]) // [R5]
        else $error("reserved lane rate on pin");
    a_rate_refuse_keeps: assert property (s_rate_bad_write |=> $stable(rate_shadow) && irq_status[`PLSC_IRQ_REFUSE]) // [R5]
        else $error("reserved rate write was not refused");
    a_train_code_legal: assert property (ts_legal(training_state)) // [R3]
        else $error("training state pin shows an undefined code");
    a_train_reaches_pin: assert property (s_train_good_write ##1 (!(acc_wr && hit_train))[*1] ##[0:8] pipe_rise |=> training_state == train_shadow) // [R4]
        else $error("written training state did not reach the pin");
    a_pins_move_on_rise: assert property (!$stable(training_state) || !$stable(lane_rate_select) |-> $past(pipe_rise)) // [R13]
        else $error("link outputs moved away from a link clock rise");
    a_event_beats_clear: assert property (|irq_set |=> (irq_status & $past(irq_set)) == $past(irq_set))
        else $error("event lost to a clear");
    a_lane_idle_event: assert property (idle_evt_v[0] |=> irq_status[`PLSC_IRQ_IDLE_LSB] && (irq || !irq_enable[`PLSC_IRQ_IDLE_LSB])) // [R10]
        else $error("lane idle change not recorded");
endmodule // plsc_top
`default_nettype wire

// ===== sim/plsc_phy_model.sv
// Behavioural PHY model: link clock and per-lane receive status
`timescale 1ns/1ps
`default_nettype none
module plsc_phy_model (
    input  wire logic        float_rx,
    input  wire logic [7:0]  want_idle,
    input  wire logic [23:0] want_status,
    output logic             pipe_pclk,
    output logic [7:0]       rx_idle_detect,
    output logic [23:0]      rx_status_code
);
    // ****************************************
    // Free-running interface clock, 200 ns
    // ****************************************
    initial
    begin
        pipe_pclk = 1'b0;
        rx_idle_detect = 8'h00;
        rx_status_code = 24'h000000;
        forever #100 pipe_pclk = ~pipe_pclk;
    end
    // Lane inputs move only on link clock rises; released lines float
    always @(posedge pipe_pclk)
    begin
        rx_idle_detect <= float_rx ? 8'hzz : want_idle;
        rx_status_code <= float_rx ? 24'hzzzzzz : want_status;
    end
endmodule // plsc_phy_model
`default_nettype wire

// ===== sim/plsc_tb_top.sv
// Self-checking bench for the lane status and control block
`timescale 1ns/1ps
`default_nettype none
`include "plsc_defs.svh"
module plsc_tb_top;
    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pipe_pclk;
    logic [7:0]  idle;
    logic [23:0] status;
    logic [4:0]  ts;
    logic [1:0]  rate;
    logic [7:0]  swing;
    logic [23:0] margin;
    logic [15:0] power;
    logic        irq;
    logic        float_rx;
    logic [7:0]  want_idle;
    logic [23:0] want_status;
    logic [31:0] rd;
    logic        er;
    int          err_count;
    int          cmp_count;

    plsc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pipe_pclk(pipe_pclk),
        .rx_idle_detect(idle), .rx_status_code(status), .training_state(ts),
        .lane_rate_select(rate), .tx_swing_select(swing), .tx_level_margin(margin),
        .power_state_request(power), .irq(irq));
    plsc_phy_model phy (.float_rx(float_rx), .want_idle(want_idle),
        .want_status(want_status), .pipe_pclk(pipe_pclk), .rx_idle_detect(idle),
        .rx_status_code(status));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pins load at the next link clock rise plus the sync delay
    task automatic settle();
        repeat (24) @(posedge pclk);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_train();
        logic [4:0] c [14] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h09, 5'h0c,
            5'h0d, 5'h0f, 5'h10, 5'h11, 5'h13, 5'h15, 5'h1a};
        chk({ts, rate, swing, power}, 0);
        chk(margin, 0);
        foreach (c[i])
        begin
            apb(1'b1, `PLSC_OFF_TRAIN, {27'h0, c[i]});
            settle();
            chk({er, ts}, {1'b0, c[i]});
        end
        apb(1'b1, `PLSC_OFF_TRAIN, 32'h00000002);
        settle();
        chk({er, ts}, {1'b1, 5'h1a});
    endtask

    task automatic t_rate();
        apb(1'b1, `PLSC_OFF_RATE, 32'h00000001);
        apb(1'b1, `PLSC_OFF_RATE, 32'h00000002);
        chk(er, 1'b1);
        apb(1'b1, `PLSC_OFF_RATE, 32'h00000003);
        settle();
        chk({er, rate}, 3'h5);
    endtask

    task automatic t_lane();
        logic [2:0]  mt [8] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1};
        logic [23:0] em;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, `PLSC_OFF_LANE_BASE + 12'(4 * i), {26'h0, 2'(i), mt[i], i[0]});
            em[3*i +: 3] = mt[i];
        end
        apb(1'b1, `PLSC_OFF_LANE_BASE, 32'h00000004);
        chk(er, 1'b1);
        apb(1'b1, `PLSC_OFF_LANE_BASE, 32'h00000006);
        chk(er, 1'b1);
        settle();
        chk(swing, 8'haa);
        chk(margin, em);
        chk(power, 16'he4e4);
    endtask

    task automatic t_irq();
        apb(1'b1, `PLSC_OFF_IRQ_CLR, 32'h0001ffff);
        apb(1'b1, `PLSC_OFF_IRQ_EN, 32'h00000001);
        want_idle <= 8'h01;
        want_status <= 24'h000020;
        settle();
        chk(irq, 1'b1);
        apb(1'b0, `PLSC_OFF_IRQ_STS, 32'h0);
        chk(rd, 32'h00000201);
        apb(1'b0, `PLSC_OFF_LANE_RX, 32'h0);
        chk(rd, 32'h00000081);
        apb(1'b1, `PLSC_OFF_IRQ_CLR, 32'h00000001);
        @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, `PLSC_OFF_IRQ_EN, 32'h00010200);
        @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, `PLSC_OFF_IRQ_STS, 32'h0);
        chk(er, 1'b1);
        apb(1'b0, 12'h018, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
    endtask

    task automatic t_float();
        float_rx <= 1'b1;
        settle();
        settle();
        chk({ts, rate, swing, power}, {5'h1a, 2'h1, 8'haa, 16'he4e4});
        chk(margin, 24'h23eb08);
    endtask

    // ****************************************
    // Main sequence, clock, watchdog
    // ****************************************
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    initial
    begin
        #300us;
        err_count++;
        print_verdict();
    end

    initial
    begin
        presetn = 1'b0;
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        float_rx = 1'b0;
        want_idle = 8'h00;
        want_status = 24'h000000;
        err_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_train();
        t_rate();
        t_lane();
        t_irq();
        t_float();
        print_verdict();
    end
endmodule // plsc_tb_top
`default_nettype wire
